// File: core/cis_sequencer.sv
`timescale 1ns/1ps
module cis_sequencer
    import cis_pkg::*;
#(
    parameter int unsigned N           = 8,
    parameter logic [N-1:0] LEVEL_TYPE = '0,
    parameter logic [15:0] BOOT_BASE   = BOOT_BASE_DEF
) (
    input  wire logic              clock,
    input  wire logic              resetn,
    input  wire logic [N-1:0]      source_event,
    input  wire logic [N-1:0]      source_enable,
    input  wire logic [N-1:0]      flag_clear_write,
    input  wire logic              global_enable_op,
    input  wire logic              global_disable_op,
    input  wire logic              return_from_handler_op,
    input  wire logic              status_write,
    input  wire logic              status_write_i,
    input  wire logic              instr_boundary,
    input  wire logic              sleeping,
    input  wire logic              vector_table_relocate,
    input  wire logic              boot_reset_vector_fuse,
    input  wire logic              app_section_lock_bit,
    input  wire logic              boot_section_lock_bit,
    input  wire logic [15:0]       current_pc,
    input  wire logic [15:0]       return_pc,
    output logic [N-1:0]           pending_flag,
    output logic                   global_enable,
    output logic                   core_stall,
    output logic                   pc_load,
    output logic [15:0]            pc_target,
    output logic [15:0]            reset_vector,
    output logic                   stack_write,
    output logic                   stack_read,
    output logic [7:0]             stack_byte,
    output logic [15:0]            stack_pointer,
    output logic                   taken,
    output logic [7:0]             taken_index
);
    // ******************************************************
    // Request gating
    // ******************************************************
    logic [N-1:0]  request;
    logic          arb_any;
    logic [7:0]    arb_index;
    logic [15:0]   arb_vector;
    logic          in_boot;
    logic          locked;
    logic          hold_one;
    logic          take;

    assign reset_vector = boot_reset_vector_fuse ? BOOT_BASE : APP_BASE;
    assign in_boot      = current_pc >= BOOT_BASE;
    assign locked       = (vector_table_relocate ? app_section_lock_bit && !in_boot
                                                 : boot_section_lock_bit && in_boot);
    assign request      = (LEVEL_TYPE & source_event | ~LEVEL_TYPE & pending_flag)
                          & source_enable;

    cis_arbiter #(.N(N)) u_arb (
        .request (request),
        .base    (vector_table_relocate ? BOOT_BASE : APP_BASE),
        .any     (arb_any),
        .index   (arb_index),
        .vector  (arb_vector)
    );

    cis_state_t    state;
    cis_state_t    next_state;
    logic [2:0]    count;
    logic [2:0]    next_count;
    logic [7:0]    cur_index;
    logic [7:0]    next_cur_index;
    logic [15:0]   cur_vector;
    logic [15:0]   next_cur_vector;
    logic [N-1:0]  next_pending_flag;
    logic          next_global_enable;
    logic          next_hold_one;
    logic [15:0]   next_stack_pointer;

    // boundary only, registered enable, live disable, one-instruction hold
    assign take = (state == CIS_RUN) && instr_boundary && arb_any && global_enable
                  && !global_disable_op && !hold_one && !locked
                  && !return_from_handler_op;

    // ******************************************************
    // Sequencer
    // ******************************************************
    always_comb begin
        next_state         = state;
        next_count         = count;
        next_cur_index     = cur_index;
        next_cur_vector    = cur_vector;
        next_global_enable = global_enable;
        next_hold_one      = hold_one;
        next_stack_pointer = stack_pointer;
        // Set wins over both clears: an event this cycle is never lost
        next_pending_flag  = pending_flag & ~flag_clear_write;
        pc_load            = 1'b0;
        pc_target          = cur_vector;
        stack_write        = 1'b0;
        stack_read         = 1'b0;
        stack_byte         = 8'h00;
        taken              = 1'b0;
        if (instr_boundary && hold_one)
            next_hold_one = 1'b0;
        if (status_write)
            next_global_enable = status_write_i;
        if (global_enable_op) begin
            next_global_enable = 1'b1;
            next_hold_one      = 1'b1;
        end
        if (global_disable_op)
            next_global_enable = 1'b0;
        unique case (state)
            CIS_RUN: begin
                if (take) begin
                    taken              = 1'b1;
                    next_cur_index     = arb_index;
                    next_cur_vector    = arb_vector;
                    next_global_enable = 1'b0;
                    if (!LEVEL_TYPE[arb_index[$clog2(N)-1:0]])
                        next_pending_flag[arb_index[$clog2(N)-1:0]] = 1'b0;
                    next_count = 3'(sleeping ? WAKE_EXTRA_CYC - 1 : RESPONSE_CYC - 1);
                    next_state = sleeping ? CIS_WAKE : CIS_ENTRY;
                end else if (return_from_handler_op && instr_boundary) begin
                    next_count = 3'(RETURN_CYC - 1);
                    next_state = CIS_EXIT;
                end
            end
            CIS_WAKE: begin
                next_count = count - 3'h1;
                if (count == CNT_RESET) begin
                    next_count = 3'(RESPONSE_CYC - 1);
                    next_state = CIS_ENTRY;
                end
            end
            CIS_ENTRY: begin
                next_count = count - 3'h1;
                if (count < 3'(PC_BYTES)) begin
                    stack_write        = 1'b1;
                    stack_byte         = count == 3'h2 ? 8'h00 : return_pc[8*count[0] +: 8];
                    next_stack_pointer = stack_pointer - 16'h1;
                end
                if (count == CNT_RESET) begin
                    pc_load    = 1'b1;
                    next_state = CIS_RUN;
                end
            end
            CIS_EXIT: begin
                next_count = count - 3'h1;
                if (count < 3'(PC_BYTES)) begin
                    stack_read         = 1'b1;
                    next_stack_pointer = stack_pointer + 16'h1;
                end
                if (count == CNT_RESET) begin
                    next_global_enable = 1'b1;
                    next_hold_one      = 1'b1;
                    next_state         = CIS_RUN;
                end
            end
            default: next_state = CIS_RUN;
        endcase
        next_pending_flag = next_pending_flag | (source_event & ~LEVEL_TYPE);
    end

    assign core_stall  = state != CIS_RUN;
    assign taken_index = cur_index;

    // single undivided clock, every register clocked each edge
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state         <= CIS_RUN;
            count         <= CNT_RESET;
            cur_index     <= 8'h00;
            cur_vector    <= APP_BASE;
            pending_flag  <= '0;
            global_enable <= 1'b0;
            hold_one      <= 1'b0;
            stack_pointer <= SP_RESET;
        end else begin
            state         <= next_state;
            count         <= next_count;
            cur_index     <= next_cur_index;
            cur_vector    <= next_cur_vector;
            pending_flag  <= next_pending_flag;
            global_enable <= next_global_enable;
            hold_one      <= next_hold_one;
            stack_pointer <= next_stack_pointer;
        end
    end

    // ******************************************************
    // Checks
    // ******************************************************
    property p_entry_clears_ie;
        @(posedge clock) disable iff (!resetn) taken |=> !global_enable;
    endproperty
    a_entry_clears_ie: assert property (p_entry_clears_ie) else $error("ie set after entry");

    property p_response_len;
        @(posedge clock) disable iff (!resetn)
            taken && !sleeping |-> ##5 pc_load;
    endproperty
    a_response_len: assert property (p_response_len) else $error("response not 5 cycles");

    property p_wake_len;
        @(posedge clock) disable iff (!resetn)
            taken && sleeping |=> !pc_load [*8] ##1 !pc_load ##1 pc_load;
    endproperty
    a_wake_len: assert property (p_wake_len) else $error("wake response not 10 cycles");

    property p_return_sets_ie;
        @(posedge clock) disable iff (!resetn)
            state == CIS_RUN && next_state == CIS_EXIT
            |-> ##5 state == CIS_EXIT ##1 global_enable && state == CIS_RUN;
    endproperty
    a_return_sets_ie: assert property (p_return_sets_ie) else $error("return sequence");

    property p_cli_blocks;
        @(posedge clock) disable iff (!resetn) global_disable_op |-> !taken;
    endproperty
    a_cli_blocks: assert property (p_cli_blocks) else $error("taken during disable op");

    property p_sei_delay;
        @(posedge clock) disable iff (!resetn)
            global_enable_op && !global_disable_op |=> !taken;
    endproperty
    a_sei_delay: assert property (p_sei_delay) else $error("taken right after enable");

    property p_needs_enable;
        @(posedge clock) disable iff (!resetn)
            taken |-> global_enable && source_enable[arb_index[$clog2(N)-1:0]];
    endproperty
    a_needs_enable: assert property (p_needs_enable) else $error("taken without enable");

    property p_flag_cleared;
        @(posedge clock) disable iff (!resetn)
            taken && !LEVEL_TYPE[arb_index[$clog2(N)-1:0]]
            && !source_event[arb_index[$clog2(N)-1:0]]
            |=> !pending_flag[cur_index[$clog2(N)-1:0]];
    endproperty
    a_flag_cleared: assert property (p_flag_cleared) else $error("flag not cleared");

    property p_three_pushes;
        @(posedge clock) disable iff (!resetn)
            taken && !sleeping |=> ##2 stack_write [*3];
    endproperty
    a_three_pushes: assert property (p_three_pushes) else $error("push count wrong");

    property p_return_pops;
        @(posedge clock) disable iff (!resetn)
            state == CIS_RUN && next_state == CIS_EXIT |=> ##2 stack_read [*3];
    endproperty
    a_return_pops: assert property (p_return_pops) else $error("pop count wrong");

    property p_ret_one_instr;
        @(posedge clock) disable iff (!resetn)
            state == CIS_EXIT && next_state == CIS_RUN |=> !taken;
    endproperty
    a_ret_one_instr: assert property (p_ret_one_instr) else $error("taken after return");

    property p_lock_blocks;
        @(posedge clock) disable iff (!resetn) locked |-> !taken;
    endproperty
    a_lock_blocks: assert property (p_lock_blocks) else $error("taken while locked");

    property p_level_no_flag;
        @(posedge clock) disable iff (!resetn) (pending_flag & LEVEL_TYPE) == '0;
    endproperty
    a_level_no_flag: assert property (p_level_no_flag) else $error("level source flagged");

    property p_push_dec;
        @(posedge clock) disable iff (!resetn)
            stack_write |=> stack_pointer == $past(stack_pointer) - 16'h1;
    endproperty
    a_push_dec: assert property (p_push_dec) else $error("push pointer step");

    property p_pop_inc;
        @(posedge clock) disable iff (!resetn)
            stack_read |=> stack_pointer == $past(stack_pointer) + 16'h1;
    endproperty
    a_pop_inc: assert property (p_pop_inc) else $error("pop pointer step");

    property p_stall_no_take;
        @(posedge clock) disable iff (!resetn) core_stall |-> !taken;
    endproperty
    a_stall_no_take: assert property (p_stall_no_take) else $error("taken while stalled");
endmodule : cis_sequencer

// File: core/cis_pkg.sv
package cis_pkg;
    // Vector and program counter geometry
    localparam int unsigned PC_W           = 16;
    localparam int unsigned VEC_STRIDE     = 2;
    localparam logic [15:0] APP_BASE       = 16'h0000;
    localparam logic [15:0] BOOT_BASE_DEF  = 16'h7000;
    localparam logic [15:0] SP_RESET       = 16'h10ff;
    // Timing counts, in clock cycles
    localparam int unsigned RESPONSE_CYC   = 5;
    localparam int unsigned WAKE_EXTRA_CYC = 5;
    localparam int unsigned RETURN_CYC     = 5;
    localparam int unsigned PC_BYTES       = 3;
    localparam logic [2:0]  CNT_RESET      = 3'h0;

    typedef enum logic [3:0] {
        CIS_RUN   = 4'h1,
        CIS_WAKE  = 4'h2,
        CIS_ENTRY = 4'h4,
        CIS_EXIT  = 4'h8
    } cis_state_t;
endpackage : cis_pkg

// File: core/cis_arbiter.sv
`timescale 1ns/1ps
module cis_arbiter
    import cis_pkg::*;
#(
    parameter int unsigned N = 8
) (
    input  wire logic [N-1:0]    request,
    input  wire logic [15:0]     base,
    output logic                 any,
    output logic [7:0]           index,
    output logic [15:0]          vector
);
    // Lowest index wins; vector 0 is reset so sources start at slot 1
    always_comb begin
        any   = 1'b0;
        index = 8'h00;
        for (int i = N - 1; i >= 0; i--) begin
            if (request[i]) begin
                any   = 1'b1;
                index = 8'(i);
            end
        end
        vector = base + 16'((32'(index) + 32'd1) * VEC_STRIDE);
    end
endmodule : cis_arbiter

// File: tb/cis_cpu_model.sv
`timescale 1ns/1ps
// ****************
// Pipeline and stack model
// ****************
module cis_cpu_model (
    input  wire logic        clock,
    input  wire logic        resetn,
    input  wire logic        core_stall,
    input  wire logic        multi,
    input  wire logic        stack_write,
    input  wire logic [7:0]  stack_byte,
    output logic             instr_boundary,
    output logic [23:0]      pushed
);
    // A multi-cycle instruction keeps the boundary low until it completes
    assign instr_boundary = !core_stall && !multi;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pushed <= 24'h000000;
        end else if (stack_write) begin
            pushed <= {pushed[15:0], stack_byte};
        end
    end
endmodule : cis_cpu_model

// File: tb/cis_sequencer_tb.sv
`timescale 1ns/1ps
// ****************
// Sequencer testbench
// ****************
module cis_sequencer_tb import cis_pkg::*; ;
    logic        clock = 1'b0;
    logic        resetn, global_enable_op, global_disable_op, return_from_handler_op;
    logic        status_write, status_write_i, sleeping, vector_table_relocate;
    logic        boot_reset_vector_fuse, multi;
    logic        app_section_lock_bit, boot_section_lock_bit;
    logic [7:0]  source_event, source_enable, flag_clear_write, pending_flag, stack_byte;
    logic [7:0]  taken_index;
    logic [15:0] pc_target, reset_vector, stack_pointer, current_pc;
    logic [23:0] pushed;
    logic        global_enable, core_stall, pc_load, stack_write, stack_read, taken;
    logic        instr_boundary;
    int          error_cnt = 0;
    int          n_checks = 0;

    always #2 clock = ~clock;

    cis_sequencer #(.LEVEL_TYPE(8'h80)) uut (
        .clock, .resetn, .source_event, .source_enable, .flag_clear_write,
        .global_enable_op, .global_disable_op, .return_from_handler_op, .status_write,
        .status_write_i, .instr_boundary, .sleeping, .vector_table_relocate,
        .boot_reset_vector_fuse, .app_section_lock_bit, .boot_section_lock_bit,
        .current_pc, .return_pc(16'h1234), .pending_flag, .global_enable,
        .core_stall, .pc_load, .pc_target, .reset_vector, .stack_write, .stack_read,
        .stack_byte, .stack_pointer, .taken, .taken_index);
    cis_cpu_model cpu (.clock, .resetn, .core_stall, .multi, .stack_write, .stack_byte,
        .instr_boundary, .pushed);

    task chk(input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            error_cnt++;
            $display("BAD %0t seen %h exp %h", $time, s, e);
        end
    endtask : chk

    task results;
        if (error_cnt == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : results

    // Inputs move 1 ns after the edge; sampling happens there before driving
    task tick;
        @(posedge clock);
        #1;
    endtask : tick

    task serve(input logic [7:0] idx, input logic [15:0] vec, input int cyc,
               input logic [15:0] spx);
        int n;
        n = 0;
        // Let combinational outputs settle after the caller's last drive
        #1;
        while (taken !== 1'b1 && n < 40) begin
            tick;
            n++;
        end
        chk(taken, 1);
        n = 0;
        do begin
            tick;
            n++;
        end while (pc_load !== 1'b1 && n < 20);
        chk(n, cyc);
        chk(pc_target, vec);
        chk(taken_index, idx);
        chk(global_enable, 0);
        chk(pending_flag[idx], 0);
        tick;
        chk(pushed, 24'h001234);
        chk(stack_pointer, spx);
    endtask : serve

    // Counts stall cycles, not the enable bit: a nested return finds it already set
    task ret_h(input logic [15:0] spx);
        int n;
        int r;
        return_from_handler_op = 1'b1;
        tick;
        return_from_handler_op = 1'b0;
        n = 0;
        r = 0;
        while (core_stall !== 1'b0 && n < 20) begin
            if (stack_read === 1'b1)
                r++;
            tick;
            n++;
        end
        chk(n, RETURN_CYC);
        chk(r, PC_BYTES);
        chk(global_enable, 1);
        chk(taken, 0);
        tick;
        chk(stack_pointer, spx);
    endtask : ret_h

    initial begin
        {resetn, global_enable_op, global_disable_op, return_from_handler_op} = 4'h0;
        {status_write, status_write_i, sleeping, vector_table_relocate} = 4'h0;
        {boot_reset_vector_fuse, multi, app_section_lock_bit, boot_section_lock_bit} = 4'h0;
        current_pc = 16'h0100;
        {source_event, source_enable, flag_clear_write} = 24'h000000;
        repeat (6) @(posedge clock);
        #1 resetn = 1'b1;
        chk(stack_pointer, SP_RESET);
        chk(reset_vector, APP_BASE);
        boot_reset_vector_fuse = 1'b1;
        tick;
        chk(reset_vector, BOOT_BASE_DEF);
        source_event = 8'h0a;
        tick;
        source_event = 8'h00;
        source_enable = 8'h0b;
        tick;
        chk(pending_flag, 8'h0a);
        global_enable_op = 1'b1;
        tick;
        global_enable_op = 1'b0;
        chk(taken, 0);
        serve(8'h01, 16'h0004, RESPONSE_CYC, SP_RESET - 3);
        chk(pending_flag, 8'h08);
        ret_h(SP_RESET);
        serve(8'h03, 16'h0008, RESPONSE_CYC, SP_RESET - 3);
        source_event = 8'h01;
        tick;
        source_event = 8'h00;
        chk(taken, 0);
        {status_write, status_write_i} = 2'h3;
        tick;
        {status_write, status_write_i} = 2'h0;
        serve(8'h00, 16'h0002, RESPONSE_CYC, SP_RESET - 6);
        ret_h(SP_RESET - 3);
        ret_h(SP_RESET);
        source_enable = 8'h00;
        source_event = 8'h30;
        tick;
        source_event = 8'h00;
        flag_clear_write = 8'h20;
        tick;
        flag_clear_write = 8'h00;
        chk(pending_flag, 8'h10);
        source_enable = 8'h04;
        source_event = 8'h04;
        global_disable_op = 1'b1;
        #1 chk(taken, 0);
        tick;
        {source_event, global_disable_op} = 9'h000;
        repeat (3) tick;
        chk({global_enable, taken}, 2'b00);
        // Software restores the enable bit, then disables in the very cycle a take is due
        {status_write, status_write_i} = 2'h3;
        tick;
        {status_write, status_write_i, global_disable_op} = 3'h1;
        #1 chk(taken, 0);
        tick;
        global_disable_op = 1'b0;
        chk(global_enable, 0);
        {vector_table_relocate, sleeping, global_enable_op} = 3'h7;
        tick;
        global_enable_op = 1'b0;
        serve(8'h02, BOOT_BASE_DEF + 16'h6, RESPONSE_CYC + WAKE_EXTRA_CYC, SP_RESET - 3);
        {vector_table_relocate, sleeping} = 2'h0;
        ret_h(SP_RESET);
        {multi, source_enable, source_event} = 17'h10404;
        tick;
        source_event = 8'h00;
        repeat (3) tick;
        chk(taken, 0);
        multi = 1'b0;
        serve(8'h02, 16'h0006, RESPONSE_CYC, SP_RESET - 3);
        ret_h(SP_RESET);
        {source_enable, source_event} = 16'h0080;
        repeat (2) tick;
        {source_enable, source_event} = 16'h8000;
        repeat (4) tick;
        chk(taken, 0);
        source_event = 8'h80;
        serve(8'h07, 16'h0010, RESPONSE_CYC, SP_RESET - 3);
        source_event = 8'h00;
        ret_h(SP_RESET);
        {boot_section_lock_bit, current_pc, source_enable} = {1'b1, 16'h7100, 8'h10};
        repeat (2) tick;
        chk(taken, 0);
        {app_section_lock_bit, vector_table_relocate, current_pc} = {2'h3, 16'h0100};
        repeat (2) tick;
        chk(taken, 0);
        app_section_lock_bit = 1'b0;
        serve(8'h04, BOOT_BASE_DEF + 16'ha, RESPONSE_CYC, SP_RESET - 3);
        vector_table_relocate = 1'b0;
        ret_h(SP_RESET);
        results;
    end

    initial begin
        #20000;
        error_cnt++;
        results;
    end
endmodule : cis_sequencer_tb
